// *** rtl/serial_link_lane_config_regs.v ***
// Serial link lane configuration register bank with lane crossbar and checksums
//
// Decided for this implementation: the strobed register port.
`include "lane_cfg_regs.vh"

module serial_link_lane_config_regs (
  input wire CLK,
  input wire RESET_N,
  input wire [`ADDR_W-1:0] ADDR,
  input wire [`DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [`DATA_W-1:0] RDATA,
  input wire DENSE_PACKING_FLAG,
  input wire [4:0] CONTROL_WORDS_PER_FRAME,
  input wire [7:0] LINK_PARAM_SUM,
  input wire [`LANE_W-1:0] LOGICAL_LANE0_DATA,
  input wire [`LANE_W-1:0] LOGICAL_LANE1_DATA,
  input wire [`LANE_W-1:0] LOGICAL_LANE2_DATA,
  input wire [`LANE_W-1:0] LOGICAL_LANE3_DATA,
  output reg [`LANE_W-1:0] SERIAL_OUTPUT_LANE_ZERO_DATA,
  output reg [`LANE_W-1:0] SERIAL_OUTPUT_LANE_ONE_DATA,
  output wire SERIAL_OUTPUT_LANE_ZERO_PWRDN,
  output wire SERIAL_OUTPUT_LANE_ONE_PWRDN,
  output wire [2:0] SERIAL_OUTPUT_LANE_ZERO_SWING,
  output wire [2:0] SERIAL_OUTPUT_LANE_ONE_SWING
);

  // Address decode for the write strobes; the read mux decodes ADDR in its own case
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // Crossbar pick; codes 4 to 7 are undefined and send an idle zero word
  function [`LANE_W-1:0] lane_pick;
    input [2:0] sel;
    input [`LANE_W-1:0] d0;
    input [`LANE_W-1:0] d1;
    input [`LANE_W-1:0] d2;
    input [`LANE_W-1:0] d3;
    begin
      case (sel)
        3'h0: begin
          lane_pick = d0;
        end
        3'h1: begin
          lane_pick = d1;
        end
        3'h2: begin
          lane_pick = d2;
        end
        3'h3: begin
          lane_pick = d3;
        end
        default: begin
          lane_pick = {`LANE_W{1'b0}};
        end
      endcase
    end
  endfunction

  // Forced-down lane sends zeros so the receiver never sees a stale word
  function [`LANE_W-1:0] lane_gate;
    input [`LANE_W-1:0] d;
    input down;
    begin
      if (down) begin
        lane_gate = {`LANE_W{1'b0}};
      end else begin
        lane_gate = d;
      end
    end
  endfunction

  // Assignment readback; bits 7 and 3 always read zero
  function [`DATA_W-1:0] sel_word;
    input [2:0] rsv;
    input [2:0] sel;
    begin
      sel_word = {1'b0, rsv, 1'b0, sel};
    end
  endfunction

  // Swing readback; bits 7 to 3 read zero
  function [`DATA_W-1:0] swing_word;
    input [2:0] code;
    begin
      swing_word = {5'h00, code};
    end
  endfunction

  // Writable state
  reg [7:0] power_down_r;
  reg [7:0] power_down_nxt;
  reg [2:0] lane0_sel_r;
  reg [2:0] lane0_sel_nxt;
  reg [2:0] lane0_sel_rsv_r;
  reg [2:0] lane0_sel_rsv_nxt;
  reg [2:0] lane1_sel_r;
  reg [2:0] lane1_sel_nxt;
  reg [2:0] lane1_sel_rsv_r;
  reg [2:0] lane1_sel_rsv_nxt;
  reg [2:0] lane0_swing_r;
  reg [2:0] lane0_swing_nxt;
  reg [2:0] lane1_swing_r;
  reg [2:0] lane1_swing_nxt;

  // Readback and datapath
  reg [`DATA_W-1:0] rdata_nxt;
  reg [`LANE_W-1:0] lane0_data_nxt;
  reg [`LANE_W-1:0] lane1_data_nxt;
  wire [7:0] lane0_checksum;
  wire [7:0] lane1_checksum;
  wire [7:0] format_readback;

  wire wr_power_down;
  wire wr_lane0_sel;
  wire wr_lane1_sel;
  wire wr_lane0_swing;
  wire wr_lane1_swing;

  assign wr_power_down = WR && hit(ADDR, `OFS_LANE_POWER_DOWN);
  assign wr_lane0_sel = WR && hit(ADDR, `OFS_LANE0_LOGICAL_SELECT);
  assign wr_lane1_sel = WR && hit(ADDR, `OFS_LANE1_LOGICAL_SELECT);
  assign wr_lane0_swing = WR && hit(ADDR, `OFS_LANE0_DRIVE_SWING);
  assign wr_lane1_swing = WR && hit(ADDR, `OFS_LANE1_DRIVE_SWING);

  // Format readback tracks the link core live; bits 6:5 read zero
  assign format_readback = {DENSE_PACKING_FLAG, 2'b00, CONTROL_WORDS_PER_FRAME}; // RULE_01 RULE_02

  // Power-down register keeps all eight bits, reserved ones included
  always @* begin
    power_down_nxt = power_down_r;
    if (wr_power_down) begin
      power_down_nxt = WDATA;
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      power_down_r <= `RST_LANE_POWER_DOWN;
    end else begin
      power_down_r <= power_down_nxt;
    end
  end

  assign SERIAL_OUTPUT_LANE_ZERO_PWRDN = power_down_r[`POS_PD_LANE0]; // RULE_05
  assign SERIAL_OUTPUT_LANE_ONE_PWRDN = power_down_r[`POS_PD_LANE1]; // RULE_06

  // Lane 0 assignment; bits 7 and 3 are read-only zero
  always @* begin
    lane0_sel_nxt = lane0_sel_r;
    if (wr_lane0_sel) begin
      lane0_sel_nxt = WDATA[`POS_SEL_HI:0];
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      lane0_sel_r <= `RST_LANE0_SEL; // RULE_07
    end else begin
      lane0_sel_r <= lane0_sel_nxt;
    end
  end

  // Reserved field is stored so software reads back what it wrote
  always @* begin
    lane0_sel_rsv_nxt = lane0_sel_rsv_r;
    if (wr_lane0_sel) begin
      lane0_sel_rsv_nxt = WDATA[`POS_SEL_RSV_HI:`POS_SEL_RSV_LO];
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      lane0_sel_rsv_r <= `RST_LANE0_SEL_RSV;
    end else begin
      lane0_sel_rsv_r <= lane0_sel_rsv_nxt;
    end
  end

  // Lane 1 assignment
  always @* begin
    lane1_sel_nxt = lane1_sel_r;
    if (wr_lane1_sel) begin
      lane1_sel_nxt = WDATA[`POS_SEL_HI:0];
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      lane1_sel_r <= `RST_LANE1_SEL; // RULE_08
    end else begin
      lane1_sel_r <= lane1_sel_nxt;
    end
  end

  // Lane 1 reserved field; its reset value differs from lane 0
  always @* begin
    lane1_sel_rsv_nxt = lane1_sel_rsv_r;
    if (wr_lane1_sel) begin
      lane1_sel_rsv_nxt = WDATA[`POS_SEL_RSV_HI:`POS_SEL_RSV_LO];
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      lane1_sel_rsv_r <= `RST_LANE1_SEL_RSV;
    end else begin
      lane1_sel_rsv_r <= lane1_sel_rsv_nxt;
    end
  end

  // Swing codes; only the low three bits are stored
  always @* begin
    lane0_swing_nxt = lane0_swing_r;
    if (wr_lane0_swing) begin
      lane0_swing_nxt = WDATA[`POS_SWING_HI:0];
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      lane0_swing_r <= `RST_SWING; // RULE_09
    end else begin
      lane0_swing_r <= lane0_swing_nxt;
    end
  end

  // Lane 1 swing, independent of lane 0
  always @* begin
    lane1_swing_nxt = lane1_swing_r;
    if (wr_lane1_swing) begin
      lane1_swing_nxt = WDATA[`POS_SWING_HI:0];
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      lane1_swing_r <= `RST_SWING; // RULE_09
    end else begin
      lane1_swing_r <= lane1_swing_nxt;
    end
  end

  assign SERIAL_OUTPUT_LANE_ZERO_SWING = lane0_swing_r; // RULE_09
  assign SERIAL_OUTPUT_LANE_ONE_SWING = lane1_swing_r; // RULE_09

  // Lane identity in each checksum is the logical lane now carried
  lane_checksum #(
    .RESET_VALUE(`RST_LANE0_CHECKSUM)
  ) u_lane0_checksum (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .param_sum(LINK_PARAM_SUM),
    .dense_packing_flag(DENSE_PACKING_FLAG),
    .control_words_per_frame(CONTROL_WORDS_PER_FRAME),
    .lane_id(lane0_sel_r),
    .checksum_r(lane0_checksum)
  ); // RULE_03 RULE_11

  lane_checksum #(
    .RESET_VALUE(`RST_LANE1_CHECKSUM)
  ) u_lane1_checksum (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .param_sum(LINK_PARAM_SUM),
    .dense_packing_flag(DENSE_PACKING_FLAG),
    .control_words_per_frame(CONTROL_WORDS_PER_FRAME),
    .lane_id(lane1_sel_r),
    .checksum_r(lane1_checksum)
  ); // RULE_04 RULE_11

  // Crossbar; a powered-down lane sends zeros so it holds no stale word
  always @* begin
    lane0_data_nxt = lane_pick(lane0_sel_r, LOGICAL_LANE0_DATA, LOGICAL_LANE1_DATA,
                               LOGICAL_LANE2_DATA, LOGICAL_LANE3_DATA); // RULE_07
    lane0_data_nxt = lane_gate(lane0_data_nxt, power_down_r[`POS_PD_LANE0]); // RULE_05
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      SERIAL_OUTPUT_LANE_ZERO_DATA <= {`LANE_W{1'b0}};
    end else begin
      SERIAL_OUTPUT_LANE_ZERO_DATA <= lane0_data_nxt;
    end
  end

  // Lane 1 crossbar and gate
  always @* begin
    lane1_data_nxt = lane_pick(lane1_sel_r, LOGICAL_LANE0_DATA, LOGICAL_LANE1_DATA,
                               LOGICAL_LANE2_DATA, LOGICAL_LANE3_DATA); // RULE_08
    lane1_data_nxt = lane_gate(lane1_data_nxt, power_down_r[`POS_PD_LANE1]); // RULE_06
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      SERIAL_OUTPUT_LANE_ONE_DATA <= {`LANE_W{1'b0}};
    end else begin
      SERIAL_OUTPUT_LANE_ONE_DATA <= lane1_data_nxt;
    end
  end

  // Read mux; idle and unmapped cycles return zero
  always @* begin
    rdata_nxt = `UNMAPPED_READ;
    if (RD) begin
      case (ADDR)
        `OFS_LINK_FORMAT_READBACK: begin
          rdata_nxt = format_readback; // RULE_01 RULE_02
        end
        `OFS_LANE0_LINK_CHECKSUM: begin
          rdata_nxt = lane0_checksum; // RULE_03
        end
        `OFS_LANE1_LINK_CHECKSUM: begin
          rdata_nxt = lane1_checksum; // RULE_04
        end
        `OFS_LANE_POWER_DOWN: begin
          rdata_nxt = power_down_r;
        end
        `OFS_LANE0_LOGICAL_SELECT: begin
          rdata_nxt = sel_word(lane0_sel_rsv_r, lane0_sel_r);
        end
        `OFS_LANE1_LOGICAL_SELECT: begin
          rdata_nxt = sel_word(lane1_sel_rsv_r, lane1_sel_r);
        end
        `OFS_LANE0_DRIVE_SWING: begin
          rdata_nxt = swing_word(lane0_swing_r);
        end
        `OFS_LANE1_DRIVE_SWING: begin
          rdata_nxt = swing_word(lane1_swing_r);
        end
        default: begin
          rdata_nxt = `UNMAPPED_READ;
        end
      endcase
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      RDATA <= `UNMAPPED_READ;
    end else begin
      RDATA <= rdata_nxt;
    end
  end

endmodule // serial_link_lane_config_regs

// *** rtl/lane_cfg_regs.vh ***
// Register offsets, field positions, reset values and widths of the lane config bank
// Overview of operation
// [RULE_01] Read-only bit reports dense packing active
// [RULE_02] Read-only five-bit control words per frame
// [RULE_03] Lane 0 checksum: parameter sum, reset 0xC3
// [RULE_04] Lane 1 checksum: parameter sum, reset 0xC4
// [RULE_05] Power-down bit 0 forces lane 0 off
// [RULE_06] Power-down bit 2 forces lane 1 off
// [RULE_07] Lane 0 takes selected logical lane, default 0
// [RULE_08] Lane 1 takes selected logical lane, default 1
// [RULE_09] Per-lane three-bit swing code, reset code 1
// [RULE_10] Software keeps reserved bits at reset values
// [RULE_11] Checksums follow every contributing parameter change
`ifndef LANE_CFG_REGS_VH
`define LANE_CFG_REGS_VH

`define ADDR_W 16
`define DATA_W 8
`define LANE_W 8

`define OFS_LINK_FORMAT_READBACK 16'h0592
`define OFS_LANE0_LINK_CHECKSUM 16'h05A0
`define OFS_LANE1_LINK_CHECKSUM 16'h05A1
`define OFS_LANE_POWER_DOWN 16'h05B0
`define OFS_LANE0_LOGICAL_SELECT 16'h05B2
`define OFS_LANE1_LOGICAL_SELECT 16'h05B3
`define OFS_LANE0_DRIVE_SWING 16'h05C0
`define OFS_LANE1_DRIVE_SWING 16'h05C1

`define POS_DENSE_PACKING 7
`define POS_CWPF_HI 4
`define POS_PD_LANE0 0
`define POS_PD_LANE1 2
`define POS_SEL_HI 2
`define POS_SEL_RSV_HI 6
`define POS_SEL_RSV_LO 4
`define POS_SWING_HI 2

`define RST_LANE0_CHECKSUM 8'hC3
`define RST_LANE1_CHECKSUM 8'hC4
`define RST_LANE_POWER_DOWN 8'hFA
`define RST_LANE0_SEL 3'h0
`define RST_LANE1_SEL 3'h1
`define RST_LANE0_SEL_RSV 3'h0
`define RST_LANE1_SEL_RSV 3'h1
`define RST_SWING 3'h1
`define UNMAPPED_READ 8'h00

`endif

// *** rtl/lane_checksum.v ***
// One lane's link checksum, kept modulo 256 and refreshed every cycle
`include "lane_cfg_regs.vh"

module lane_checksum #(
  parameter [7:0] RESET_VALUE = 8'h00
) (
  input wire CLK,
  input wire RESET_N,
  input wire [7:0] param_sum,
  input wire dense_packing_flag,
  input wire [4:0] control_words_per_frame,
  input wire [2:0] lane_id,
  output reg [7:0] checksum_r
);

  // Eight-bit wrap is the modulo 256 of the sum
  function [7:0] add_mod256;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      add_mod256 = s[7:0];
    end
  endfunction

  reg [7:0] checksum_nxt;

  // Recomputed every cycle, so any parameter change shows one cycle later
  always @* begin
    checksum_nxt = add_mod256(param_sum, {7'h00, dense_packing_flag});
    checksum_nxt = add_mod256(checksum_nxt, {3'h0, control_words_per_frame});
    checksum_nxt = add_mod256(checksum_nxt, {5'h00, lane_id}); // RULE_11
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      checksum_r <= RESET_VALUE;
    end else begin
      checksum_r <= checksum_nxt;
    end
  end

endmodule // lane_checksum

// *** test/lane_cfg_checker.sv ***
// Port-level assertions for the lane configuration register bank
module lane_cfg_checker (
  input wire CLK,
  input wire RESET_N,
  input wire [15:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire DENSE_PACKING_FLAG,
  input wire [4:0] CONTROL_WORDS_PER_FRAME,
  input wire [7:0] SERIAL_OUTPUT_LANE_ZERO_DATA,
  input wire SERIAL_OUTPUT_LANE_ZERO_PWRDN,
  input wire SERIAL_OUTPUT_LANE_ONE_PWRDN,
  input wire [2:0] SERIAL_OUTPUT_LANE_ZERO_SWING,
  input wire [2:0] SERIAL_OUTPUT_LANE_ONE_SWING
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  AST_DENSE_READ: assert property (RD && ADDR == 16'h0592 |=>
    RDATA[7] == $past(DENSE_PACKING_FLAG)) else $error("dense flag readback wrong");
  AST_CWPF_READ: assert property (RD && ADDR == 16'h0592 |=>
    RDATA[6:0] == {2'b00, $past(CONTROL_WORDS_PER_FRAME)}) else $error("cwpf readback wrong");
  AST_PD0_WRITE: assert property (WR && ADDR == 16'h05B0 |=>
    SERIAL_OUTPUT_LANE_ZERO_PWRDN == $past(WDATA[0])) else $error("lane 0 power-down wrong");
  AST_PD1_WRITE: assert property (WR && ADDR == 16'h05B0 |=>
    SERIAL_OUTPUT_LANE_ONE_PWRDN == $past(WDATA[2])) else $error("lane 1 power-down wrong");
  AST_PD0_SILENT: assert property (SERIAL_OUTPUT_LANE_ZERO_PWRDN [*2] |->
    SERIAL_OUTPUT_LANE_ZERO_DATA == 8'h00) else $error("powered-down lane 0 carries data");
  AST_SW0_WRITE: assert property (WR && ADDR == 16'h05C0 |=>
    SERIAL_OUTPUT_LANE_ZERO_SWING == $past(WDATA[2:0])) else $error("lane 0 swing wrong");
  AST_SW1_WRITE: assert property (WR && ADDR == 16'h05C1 |=>
    SERIAL_OUTPUT_LANE_ONE_SWING == $past(WDATA[2:0])) else $error("lane 1 swing wrong");
  AST_SW0_HOLD: assert property (!(WR && ADDR == 16'h05C0) |=>
    $stable(SERIAL_OUTPUT_LANE_ZERO_SWING)) else $error("lane 0 swing moved");
  AST_RESET_LEVELS: assert property ($rose(RESET_N) |-> !SERIAL_OUTPUT_LANE_ZERO_PWRDN &&
    !SERIAL_OUTPUT_LANE_ONE_PWRDN && SERIAL_OUTPUT_LANE_ZERO_SWING == 3'h1 &&
    SERIAL_OUTPUT_LANE_ONE_SWING == 3'h1) else $error("reset levels wrong");
endmodule // lane_cfg_checker

bind serial_link_lane_config_regs lane_cfg_checker i_lane_cfg_checker (.CLK, .RESET_N, .ADDR,
  .WDATA, .WR, .RD, .RDATA, .DENSE_PACKING_FLAG, .CONTROL_WORDS_PER_FRAME,
  .SERIAL_OUTPUT_LANE_ZERO_DATA, .SERIAL_OUTPUT_LANE_ZERO_PWRDN, .SERIAL_OUTPUT_LANE_ONE_PWRDN,
  .SERIAL_OUTPUT_LANE_ZERO_SWING, .SERIAL_OUTPUT_LANE_ONE_SWING);

// *** test/link_receiver_model.sv ***
// Behavioural link receiver capturing both physical lanes
module link_receiver_model (
  input wire logic clk,
  input wire logic [7:0] lane0,
  input wire logic [7:0] lane1,
  input wire logic down0,
  input wire logic down1,
  output logic [7:0] rx0,
  output logic [7:0] rx1
);
  timeunit 1ns;
  timeprecision 100ps;
  // A dead lane toggles its capture so stale words never look valid
  always @(posedge clk) begin
    rx0 <= down0 ? ~rx0 : lane0;
    rx1 <= down1 ? ~rx1 : lane1;
  end
endmodule // link_receiver_model

// *** test/serial_link_lane_config_regs_bench.sv ***
// Self-checking bench for the lane configuration register bank
module serial_link_lane_config_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [15:0] ADDR = 16'h0000;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic DENSE = 1'b0;
  logic [4:0] CWPF = 5'h00;
  logic [7:0] PSUM = 8'hC3;
  logic [7:0] lg [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] RDATA, D0, D1, rx0, rx1;
  logic P0, P1;
  logic [2:0] S0, S1;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;

  serial_link_lane_config_regs i_serial_link_lane_config_regs (.CLK(CLK), .RESET_N(RESET_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DENSE_PACKING_FLAG(DENSE),
    .CONTROL_WORDS_PER_FRAME(CWPF), .LINK_PARAM_SUM(PSUM), .LOGICAL_LANE0_DATA(lg[0]),
    .LOGICAL_LANE1_DATA(lg[1]), .LOGICAL_LANE2_DATA(lg[2]), .LOGICAL_LANE3_DATA(lg[3]),
    .SERIAL_OUTPUT_LANE_ZERO_DATA(D0), .SERIAL_OUTPUT_LANE_ONE_DATA(D1),
    .SERIAL_OUTPUT_LANE_ZERO_PWRDN(P0), .SERIAL_OUTPUT_LANE_ONE_PWRDN(P1),
    .SERIAL_OUTPUT_LANE_ZERO_SWING(S0), .SERIAL_OUTPUT_LANE_ONE_SWING(S1));
  link_receiver_model i_link_receiver_model (.clk(CLK), .lane0(D0), .lane1(D1), .down0(P0),
    .down1(P1), .rx0(rx0), .rx1(rx1));

  initial forever #12.5 CLK = ~CLK;

  task complete_run;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk($sformatf("rdata %h", a), e, RDATA);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // Parameter sum chosen so the live checksums equal the reset values
  task t_reset;
    rd(16'h05A0, 8'hC3);
    rd(16'h05A1, 8'hC4);
    rd(16'h05B0, 8'hFA);
    rd(16'h05B2, 8'h00);
    rd(16'h05B3, 8'h11);
    rd(16'h05C0, 8'h01);
    rd(16'h05C1, 8'h01);
    rd(16'h0600, 8'h00);
    chk("swing", 8'h11, {1'b0, S1, 1'b0, S0});
    chk("pwrdn", 8'h00, {7'h00, P0 | P1});
  endtask

  task t_format;
    @(posedge CLK);
    DENSE <= 1'b1;
    CWPF <= 5'h1F;
    PSUM <= 8'hFF;
    wr(16'h0592, 8'h00);
    rd(16'h0592, 8'h9F);
    rd(16'h05A0, 8'h1F);
    rd(16'h05A1, 8'h20);
    wr(16'h05B2, 8'h03);
    rd(16'h05A0, 8'h22);
    wr(16'h05B2, 8'h00);
    DENSE <= 1'b0;
    CWPF <= 5'h0A;
    rd(16'h0592, 8'h0A);
  endtask

  // Non-zero lane words so a forced-down lane is told apart from idle data
  task t_pwrdn;
    @(posedge CLK);
    lg[0] <= 8'hA5;
    lg[1] <= 8'h3C;
    wr(16'h05B0, 8'hFB);
    cyc(2);
    chk("lane0 down", 8'h01, {7'h00, P0});
    chk("lane0 data", 8'h00, D0);
    chk("lane1 data", 8'h3C, D1);
    rd(16'h05B0, 8'hFB);
    wr(16'h05B0, 8'hFE);
    cyc(2);
    chk("lanes down", 8'h02, {6'h00, P1, P0});
    chk("lane1 data", 8'h00, D1);
    chk("lane0 data", 8'hA5, D0);
    wr(16'h05B0, 8'hFA);
  endtask

  task t_xbar;
    logic [7:0] s;
    for (s = 8'h00; s < 8'h04; s++) begin
      @(posedge CLK);
      for (int i = 0; i < 4; i++) lg[i] <= 8'h5A + 8'h21 * i[7:0] + s;
      wr(16'h05B2, s);
      wr(16'h05B3, 8'h10 | (8'h03 - s));
      cyc(3);
      chk("rx0", 8'h5A + 8'h21 * s + s, rx0);
      chk("rx1", 8'h5A + 8'h21 * (8'h03 - s) + s, rx1);
      rd(16'h05B3, 8'h10 | (8'h03 - s));
    end
    // Codes above logical lane 3 are undefined and send an idle zero word
    wr(16'h05B2, 8'h04);
    cyc(3);
    chk("rx0", 8'h00, rx0);
    wr(16'h05B2, 8'h00);
    wr(16'h05B3, 8'h11);
  endtask

  task t_swing;
    logic [2:0] c;
    for (int k = 0; k < 2; k++) begin
      c = k ? 3'h7 : 3'h0;
      wr(16'h05C0, {5'h1F, c});
      wr(16'h05C1, {5'h1F, ~c});
      rd(16'h05C0, {5'h00, c});
      chk("swing", {1'b0, ~c, 1'b0, c}, {1'b0, S1, 1'b0, S0});
    end
  endtask

  // Ceiling well above the roughly 125 cycles the sequence needs
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run;
    end
  end

  initial begin
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    t_reset;
    t_format;
    t_pwrdn;
    t_xbar;
    t_swing;
    complete_run;
  end
endmodule // serial_link_lane_config_regs_bench
